// ---- smsp_pkg.sv ----
package smsp_pkg;

   // Register map of the serial port.
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_MODE = 8'h15;
   localparam logic [7:0] REG_TOP = 8'h19;
   localparam logic [7:0] MODE_RESET = 8'hc0;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Upper six bits of the slave address; the last bit comes from a pin.
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h26;

   // Bit positions inside the mode byte.
   localparam int MODE_SPLIT_BIT = 7;
   localparam int MODE_PARALLEL_BIT = 6;
   localparam int MODE_SWAP_BIT = 5;
   localparam int MODE_422_BIT = 4;
   localparam int MODE_INPUT_BIT = 3;
   localparam int MODE_BW_HI_BIT = 2;
   localparam int MODE_BW_LO_BIT = 1;
   localparam int MODE_CLK_BIT = 0;

   // Analog bandwidth codes.
   localparam logic [1:0] BW_75 = 2'h0;
   localparam logic [1:0] BW_150 = 2'h1;
   localparam logic [1:0] BW_300 = 2'h2;
   localparam logic [1:0] BW_500 = 2'h3;

   // Bits per byte on the wire and the count width.
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;

   typedef struct packed {
      logic dual_port_split;
      logic parallel_out;
      logic port_swap;
      logic out_422;
      logic input_channel;
      logic [1:0] bandwidth_code;
      logic external_clock_select;
   } smsp_mode_t;

   typedef struct packed {
      logic hsync_active;
      logic hsync_source;
      logic hsync_pol;
      logic vsync_active;
      logic vsync_source;
      logic vsync_pol;
      logic sog_active;
      logic coast_pol;
   } smsp_status_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_REGA,
      ST_REGA_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } smsp_state_t;

endpackage

// ---- smsp_port.sv ----
`timescale 1ns/10ps
// Contract
// - Status bit 1 reports sync-on-green activity.
// - Status bit 0 reports hold input polarity.
// - Vsync polarity bit: 0 low, 1 high.
// - Mode bit 7 splits pixels over two ports.
// - Mode bit 6 picks interleaved or simultaneous ports.
// - Mode bit 5 swaps port phase in dual.
// - Mode bit 4 selects 4:2:2, blue released.
// - Mode bit 3 selects analog input channel.
// - Mode bits 2:1 encode analog bandwidth.
// - Mode bit 0 selects external pixel clock.
// - Start and stop detected while clock high.
// - First byte: address plus direction bit.
// - Acknowledge address 100110 plus select pin.
// - Bytes travel most significant bit first.
// - No acknowledge leaves data line released.
// - Base address, increments, saturates at 19h.
// - Base address above 19h is not acknowledged.
// - Reads start at base, then increment.
// - Repeated start accepted without stop.
module smsp_port
   import smsp_pkg::*;
(
   input wire logic SYS_CLK, // System clock, 200 MHz.
   input wire logic RST, // Asynchronous reset, active high.
   input wire logic SCL_IN, // Serial clock from the master.
   input wire logic SDA_IN, // Serial data line level.
   output logic SDA_OUT, // Serial data drive value, always low.
   output logic SDA_OE_N, // Low while the port pulls data low.
   input wire logic ADDR_SELECT_PIN, // Slave address bit 0.
   input wire smsp_status_t STATUS_IN, // Sync detector outputs.
   input wire logic PIX_EN, // One pulse per converted sample.
   input wire logic LINE_START, // Pulse at line-sync leading edge.
   output smsp_mode_t MODE, // Mode control register contents.
   output logic PORT_A_LOAD, // Port A takes the sample.
   output logic PORT_B_LOAD, // Port B takes the sample.
   output logic PORT_B_OE_N, // Low while port B drives.
   output logic BLUE_OE_N // Low while blue outputs drive.
);

   logic scl_q;
   logic sda_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   smsp_state_t state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic sda_oe_n_q;
   logic sda_out_q;
   logic wr_pulse_q;
   logic [7:0] wr_data_q;
   logic [7:0] wr_addr_q;

   smsp_mode_t mode_q;
   smsp_status_t status_q;
   logic pix_odd_q;
   logic a_load_q;
   logic b_load_q;
   logic b_oe_n_q;
   logic blue_oe_n_q;

   logic [7:0] rd_byte;
   logic [7:0] ptr_next;
   logic [7:0] rx_next;
   logic byte_done;
   logic addr_hit;
   logic base_ok;
   logic base_take;
   logic wr_take;
   logic rd_take;

   // Pins are synchronous to SYS_CLK, so one stage plus a history stage
   // is enough to see edges of the serial clock and data.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_q <= SCL_IN;
         sda_q <= SDA_IN;
         scl_prev_q <= scl_q;
         sda_prev_q <= sda_q;
      end
   end

   assign scl_rise = scl_q & ~scl_prev_q;
   assign scl_fall = ~scl_q & scl_prev_q;
   assign start_seen = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
   assign stop_seen = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

   // Data is shifted in at the bottom, so after eight bits the first bit lands in bit 7.
   assign rx_next = {rx_q[6:0], sda_q};

   // The pointer stops at the top address for reads and writes alike.
   assign ptr_next = (ptr_q >= REG_TOP) ? REG_TOP : ptr_q + 8'h01;

   // A byte is complete on the falling clock that follows its eighth bit.
   // Starts and stops win over whatever the engine would do that cycle.
   assign byte_done = scl_fall && (bit_cnt_q == BYTE_BITS) &&
                      !start_seen && !stop_seen;
   assign addr_hit = (rx_q[7:1] == {SLAVE_ADDR_HI, ADDR_SELECT_PIN});
   assign base_ok = (rx_q <= REG_TOP);
   assign base_take = byte_done && (state_q == ST_REGA) && base_ok;
   assign wr_take = byte_done && (state_q == ST_WDATA);
   assign rd_take = byte_done && (state_q == ST_RDATA);

   always_comb begin
      case (ptr_q)
         REG_STATUS: rd_byte = status_q;
         REG_MODE: rd_byte = mode_q;
         default: rd_byte = READ_ZERO;
      endcase
   end

   // Status is taken straight from the detectors every cycle.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_q <= '0;
      end else begin
         status_q <= STATUS_IN;
      end
   end

   // Protocol engine. Data is sampled on the rising serial clock and the
   // line is changed on the falling one, which relies on the master
   // keeping data steady while the clock is high.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= CNT_ZERO;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
      end else begin
         if (start_seen) begin
            // A start in mid transfer is a repeated start; the pointer
            // is kept so a read can follow a base address write.
            state_q <= ST_ADDR;
            bit_cnt_q <= CNT_ZERO;
            sda_oe_n_q <= 1'b1;
         end else if (stop_seen) begin
            state_q <= ST_IDLE;
            sda_oe_n_q <= 1'b1;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_oe_n_q <= 1'b1;
               end
               ST_ADDR, ST_REGA, ST_WDATA: begin
                  if (scl_rise) begin
                     rx_q <= rx_next;
                     bit_cnt_q <= bit_cnt_q + CNT_ONE;
                  end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
                     bit_cnt_q <= CNT_ZERO;
                     if (state_q == ST_ADDR) begin
                        if (addr_hit) begin
                           rw_q <= rx_q[0];
                           sda_oe_n_q <= 1'b0;
                           state_q <= ST_ADDR_ACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else if (state_q == ST_REGA) begin
                        if (base_ok) begin
                           sda_oe_n_q <= 1'b0;
                           state_q <= ST_REGA_ACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else begin
                        sda_oe_n_q <= 1'b0;
                        state_q <= ST_WDATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_q <= CNT_ZERO;
                     if (rw_q) begin
                        tx_q <= rd_byte;
                        sda_oe_n_q <= rd_byte[7];
                        state_q <= ST_RDATA;
                     end else begin
                        sda_oe_n_q <= 1'b1;
                        state_q <= ST_REGA;
                     end
                  end
               end
               ST_REGA_ACK, ST_WDATA_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_q <= CNT_ZERO;
                     sda_oe_n_q <= 1'b1;
                     state_q <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (scl_rise) begin
                     bit_cnt_q <= bit_cnt_q + CNT_ONE;
                  end else if (scl_fall) begin
                     if (bit_cnt_q == BYTE_BITS) begin
                        sda_oe_n_q <= 1'b1;
                        state_q <= ST_RDATA_ACK;
                     end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_n_q <= tx_q[6];
                     end
                  end
               end
               ST_RDATA_ACK: begin
                  if (scl_rise && sda_q) begin
                     // No acknowledge from the master ends the data.
                     state_q <= ST_IDLE;
                  end else if (scl_fall) begin
                     bit_cnt_q <= CNT_ZERO;
                     tx_q <= rd_byte;
                     sda_oe_n_q <= rd_byte[7];
                     state_q <= ST_RDATA;
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
                  sda_oe_n_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // The data line is open drain: the drive value stays low and only the
   // enable moves, so the device can never push the line high.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sda_out_q <= 1'b0;
      end else begin
         sda_out_q <= 1'b0;
      end
   end

   // Register pointer. It survives stops and repeated starts so a read
   // can follow the write that set the base address.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ptr_q <= 8'h00;
      end else if (base_take) begin
         ptr_q <= rx_q;
      end else if (wr_take || rd_take) begin
         ptr_q <= ptr_next;
      end
   end

   // Write strobe. Byte and address are held with the strobe so the
   // register file sees one clean request per data byte.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         wr_pulse_q <= 1'b0;
         wr_data_q <= 8'h00;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pulse_q <= wr_take;
         if (wr_take) begin
            wr_data_q <= rx_q;
            wr_addr_q <= ptr_q;
         end
      end
   end

   // Mode register. A write to the status address is acknowledged above
   // but lands nowhere, since those bits only mirror the detectors.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         mode_q <= MODE_RESET;
      end else if (wr_pulse_q && wr_addr_q == REG_MODE) begin
         mode_q.dual_port_split <= wr_data_q[MODE_SPLIT_BIT];
         mode_q.parallel_out <= wr_data_q[MODE_PARALLEL_BIT];
         mode_q.port_swap <= wr_data_q[MODE_SWAP_BIT];
         mode_q.out_422 <= wr_data_q[MODE_422_BIT];
         mode_q.input_channel <= wr_data_q[MODE_INPUT_BIT];
         mode_q.bandwidth_code <=
            wr_data_q[MODE_BW_HI_BIT:MODE_BW_LO_BIT];
         mode_q.external_clock_select <= wr_data_q[MODE_CLK_BIT];
      end
   end

   // Sample steering. pix_odd_q is low for the first sample of a line and
   // every other one after it.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pix_odd_q <= 1'b0;
         a_load_q <= 1'b0;
         b_load_q <= 1'b0;
      end else begin
         if (LINE_START) begin
            pix_odd_q <= 1'b0;
         end else if (PIX_EN) begin
            pix_odd_q <= ~pix_odd_q;
         end
         if (!mode_q.dual_port_split) begin
            a_load_q <= PIX_EN;
            b_load_q <= 1'b0;
         end else if (mode_q.parallel_out) begin
            // Both ports update together once a pair is complete.
            a_load_q <= PIX_EN & pix_odd_q;
            b_load_q <= PIX_EN & pix_odd_q;
         end else begin
            a_load_q <= PIX_EN & (pix_odd_q == mode_q.port_swap);
            b_load_q <= PIX_EN & (pix_odd_q != mode_q.port_swap);
         end
      end
   end

   // The enables lag the mode register by one cycle, so the pins float
   // only after the write has landed.
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         b_oe_n_q <= 1'b0;
         blue_oe_n_q <= 1'b0;
      end else begin
         b_oe_n_q <= ~mode_q.dual_port_split;
         blue_oe_n_q <= mode_q.out_422;
      end
   end

   assign SDA_OUT = sda_out_q;
   assign SDA_OE_N = sda_oe_n_q;
   assign MODE = mode_q;
   assign PORT_A_LOAD = a_load_q;
   assign PORT_B_LOAD = b_load_q;
   assign PORT_B_OE_N = b_oe_n_q;
   assign BLUE_OE_N = blue_oe_n_q;

endmodule

// ---- smsp_port_properties.sv ----
`timescale 1ns/10ps
module smsp_port_properties
   import smsp_pkg::*;
(
   input wire logic SYS_CLK, // Clock.
   input wire logic RST, // Reset.
   input wire logic SCL_IN, // Serial clock.
   input wire logic SDA_OE_N, // Data drive enable.
   input wire logic PIX_EN, // Sample strobe.
   input wire logic LINE_START, // Line start.
   input wire smsp_mode_t MODE, // Mode register.
   input wire logic PORT_A_LOAD, // Port A load.
   input wire logic PORT_B_LOAD, // Port B load.
   input wire logic PORT_B_OE_N, // Port B enable.
   input wire logic BLUE_OE_N // Blue enable.
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   a_mode_reset_value: assert property ($fell(RST) |->
      MODE == MODE_RESET)
      else $error("mode not at reset value");
   a_port_b_release: assert property (
      PORT_B_OE_N == !$past(MODE.dual_port_split))
      else $error("port B enable wrong");
   a_blue_release: assert property (
      BLUE_OE_N == $past(MODE.out_422))
      else $error("blue enable wrong");
   a_single_to_a: assert property (
      PIX_EN && !MODE.dual_port_split |=> PORT_A_LOAD && !PORT_B_LOAD)
      else $error("single port load wrong");
   a_interleave_one: assert property (
      PIX_EN && MODE.dual_port_split && !MODE.parallel_out |=>
      PORT_A_LOAD != PORT_B_LOAD)
      else $error("interleaved load wrong");
   a_parallel_pair: assert property (
      PIX_EN && MODE.dual_port_split && MODE.parallel_out |=>
      PORT_A_LOAD == PORT_B_LOAD)
      else $error("parallel loads differ");
   a_first_phase: assert property (
      LINE_START ##1 PIX_EN && MODE.dual_port_split &&
      !MODE.parallel_out |=> PORT_B_LOAD == MODE.port_swap)
      else $error("first sample on wrong port");
   a_no_idle_load: assert property (
      !PIX_EN |=> !PORT_A_LOAD && !PORT_B_LOAD)
      else $error("load without sample");
   a_data_steady_high: assert property (
      SCL_IN && $past(SCL_IN, 3) |-> $stable(SDA_OE_N))
      else $error("data moved while clock high");
   a_mode_clock_low: assert property (
      $changed(MODE) |-> !SCL_IN && !$past(SCL_IN))
      else $error("mode changed outside low phase");
endmodule
bind smsp_port smsp_port_properties u_props (.SYS_CLK(SYS_CLK), .RST(RST),
   .SCL_IN(SCL_IN), .SDA_OE_N(SDA_OE_N), .PIX_EN(PIX_EN),
   .LINE_START(LINE_START), .MODE(MODE), .PORT_A_LOAD(PORT_A_LOAD),
   .PORT_B_LOAD(PORT_B_LOAD), .PORT_B_OE_N(PORT_B_OE_N),
   .BLUE_OE_N(BLUE_OE_N));

// ---- smsp_master.sv ----
`timescale 1ns/10ps
// Behavioural host; data bits move only in the low clock phase, starts and stops in the high one.
module smsp_master (
   input wire logic clk, // System clock.
   input wire logic sda, // Resolved data line.
   output logic scl, // Serial clock.
   output logic sda_oe_n // Low pulls data low.
);
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end
   task automatic hp();
      repeat (4) @(posedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      hp();
      sda_oe_n <= b;
      hp();
      scl <= 1'b1;
      hp();
      r = sda;
      hp();
   endtask
   // A high first level gives a start, a low one a stop.
   task automatic cond(input logic first);
      scl <= 1'b0;
      hp();
      sda_oe_n <= first;
      hp();
      scl <= 1'b1;
      hp();
      sda_oe_n <= !first;
      hp();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

// ---- smsp_port_tb.sv ----
`timescale 1ns/10ps
module smsp_port_tb;
   import smsp_pkg::*;
   logic SYS_CLK;
   logic RST;
   logic pin;
   logic pix;
   logic lst;
   smsp_status_t stat;
   logic scl, m_oe_n, sda_oe_n, sda_out, a_ld, b_ld, b_oe_n, bl_oe_n;
   smsp_mode_t mode;
   wire logic sda = m_oe_n & (sda_oe_n | sda_out);
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = !SYS_CLK;
   end
   smsp_master host (.clk(SYS_CLK), .sda(sda), .scl(scl),
      .sda_oe_n(m_oe_n));
   smsp_port dut (.SYS_CLK(SYS_CLK), .RST(RST), .SCL_IN(scl),
      .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
      .ADDR_SELECT_PIN(pin), .STATUS_IN(stat), .PIX_EN(pix),
      .LINE_START(lst), .MODE(mode), .PORT_A_LOAD(a_ld),
      .PORT_B_LOAD(b_ld), .PORT_B_OE_N(b_oe_n), .BLUE_OE_N(bl_oe_n));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [7:0] sa(input logic rd);
      return {SLAVE_ADDR_HI, pin, rd};
   endfunction
   // Writes the first n bytes of d, leftmost byte first.
   task automatic wr(input logic [7:0] base, input logic [23:0] d,
                     input int n);
      logic ack;
      host.cond(1'b1);
      host.wbyte(sa(1'b0), ack);
      chk(ack, 1'b1);
      host.wbyte(base, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         host.wbyte(d[23 - 8 * i -: 8], ack);
         chk(ack, 1'b1);
      end
      host.cond(1'b0);
   endtask
   task automatic rd(input logic [7:0] base, input int n,
                     output logic [23:0] q);
      logic ack;
      q = 24'h0;
      host.cond(1'b1);
      host.wbyte(sa(1'b0), ack);
      host.wbyte(base, ack);
      host.cond(1'b1);
      host.wbyte(sa(1'b1), ack);
      chk(ack, 1'b1);
      for (int i = 0; i < n; i++)
         host.rbyte(i == n - 1, q[23 - 8 * i -: 8]);
      host.cond(1'b0);
   endtask
   // Two samples after a line start; bit 1 holds the first, bit 0 the
   // second, so both phases of the steering are seen.
   task automatic pulse_pix(output logic [1:0] a, output logic [1:0] b);
      lst <= 1'b1;
      @(posedge SYS_CLK);
      lst <= 1'b0;
      for (int i = 1; i >= 0; i--) begin
         pix <= 1'b1;
         @(posedge SYS_CLK);
         pix <= 1'b0;
         #1;
         a[i] = a_ld;
         b[i] = b_ld;
         @(posedge SYS_CLK);
      end
   endtask
   task automatic t_reset();
      logic [23:0] q;
      chk(mode, MODE_RESET);
      chk(b_oe_n, 1'b0);
      chk(sda_out, 1'b0);
      rd(REG_MODE, 1, q);
      chk(q[23:16], MODE_RESET);
   endtask
   // The table walks every bandwidth code and each port arrangement.
   task automatic t_mode();
      logic [7:0] v [5] = '{8'h00, 8'h1a, 8'h87, 8'ha5, 8'hc0};
      logic [23:0] q;
      logic [1:0] a, b;
      foreach (v[i]) begin
         wr(REG_MODE, {v[i], 16'h0}, 1);
         chk(mode, v[i]);
         chk(bl_oe_n, v[i][4]);
         chk(b_oe_n, !v[i][7]);
         pulse_pix(a, b);
         chk(a[1], !v[i][7] | !v[i][6] & !v[i][5]);
         chk(b[1], v[i][7] & !v[i][6] & v[i][5]);
         chk(a[0], !v[i][7] | v[i][6] | v[i][5]);
         chk(b[0], v[i][7] & (v[i][6] | !v[i][5]));
         rd(REG_MODE, 1, q);
         chk(q[23:16], v[i]);
      end
   endtask
   task automatic t_status();
      logic [7:0] p [2] = '{8'ha5, 8'h5a};
      logic [23:0] q;
      foreach (p[i]) begin
         stat <= p[i];
         wr(REG_STATUS, {~p[i], 16'h0}, 1);
         rd(REG_STATUS, 3, q);
         chk(q[23:16], p[i]);
         chk(q[15:8], 8'hc0);
         chk(q[7:0], READ_ZERO);
      end
   endtask
   task automatic t_incr();
      logic [23:0] q;
      wr(8'h13, 24'h112244, 3);
      chk(mode, 8'h44);
      wr(REG_TOP, 24'h778899, 3);
      chk(mode, 8'h44);
      rd(REG_TOP, 3, q);
      chk(q[23:16] | q[15:8] | q[7:0], READ_ZERO);
   endtask
   task automatic t_refuse();
      logic ack;
      host.cond(1'b1);
      host.wbyte(sa(1'b0) ^ 8'h02, ack);
      chk(ack, 1'b0);
      host.cond(1'b0);
      pin <= 1'b1;
      wr(REG_MODE, 24'h330000, 1);
      chk(mode, 8'h33);
      host.cond(1'b1);
      host.wbyte(sa(1'b0), ack);
      host.wbyte(8'h1a, ack);
      chk(ack, 1'b0);
      host.cond(1'b0);
   endtask
   // A reset in mid-run must bring the mode register back to power-up.
   task automatic t_rerun();
      logic [23:0] q;
      RST <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      RST <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      chk(mode, MODE_RESET);
      rd(REG_MODE, 1, q);
      chk(q[23:16], MODE_RESET);
   endtask
   initial begin
      RST <= 1'b1;
      pin <= 1'b0;
      pix <= 1'b0;
      lst <= 1'b0;
      stat <= 8'h00;
      repeat (8) @(posedge SYS_CLK);
      RST <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      t_reset();
      t_mode();
      t_status();
      t_incr();
      t_refuse();
      t_rerun();
      test_done();
   end
   // The ceiling is about three times the expected run length.
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         test_done();
      end
   end
endmodule
